// ### design/alarm_flags_pkg.sv
package alarm_flags_pkg;
    localparam int NUM_CH = 16;
    localparam int NUM_STAT = 17;
    localparam int ADDR_W = 13;
    localparam int IDX_W = 11;
    localparam int IDX_LSB = 2;
    localparam int CH_LSB = 6;
    localparam int CH_W = 4;
    localparam int COUNT_W = 28;
    typedef logic [COUNT_W-1:0] count_type;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] CH1_STATUS_IDX = 11'h01F;
    localparam logic [IDX_W-1:0] CH1_FLAGS_IDX = 11'h020;
    localparam logic [IDX_W-1:0] CH1_MASK_IDX = 11'h030;
    localparam logic [IDX_W-1:0] CH1_EDGE_IDX = 11'h031;
    localparam logic [IDX_W-1:0] CH_STRIDE_IDX = 11'h040;
    localparam logic [IDX_W-1:0] CH0_STATUS_IDX = 11'h7DF;
    localparam logic [IDX_W-1:0] CONTROL_IDX = 11'h7F0;

    // alarm status bits
    localparam int ST_SYS_AIS = 7;
    localparam int ST_LINE_AIS = 6;
    localparam int ST_PATTERN = 5;
    localparam int ST_UP = 1;
    localparam int ST_DOWN = 0;
    // event flag bits; bits 4..0 also index the line status vector
    localparam int FL_AMP = 7;
    localparam int FL_TJA = 6;
    localparam int FL_RJA = 5;
    localparam int FL_TOC = 4;
    localparam int FL_TCK = 3;
    localparam int FL_TLOS = 2;
    localparam int FL_SLOS = 1;
    localparam int FL_LLOS = 0;
    localparam int LINE_W = 5;
    // edge select bits
    localparam int ES_TOC = 4;
    localparam int ES_TCK = 3;
    localparam int ES_TLOS = 2;
    localparam int ES_LOS = 1;
    localparam logic [7:0] EDGE_WMASK = 8'h1E;
    // control bits
    localparam int CTL_AUTO = 0;
    localparam int CTL_E1 = 1;
    localparam logic [7:0] CTL_WMASK = 8'h03;

    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] EDGE_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam longint CLK_HZ = 50_000_000;
    localparam longint UP_HOLD_MS = 40;
    localparam longint DOWN_HOLD_E1_MS = 30;
    localparam longint AUTO_HOLD_DSEC = 51;
    localparam int UP_HOLD_CYC = int'((UP_HOLD_MS * CLK_HZ + 999) / 1000);
    localparam int DOWN_HOLD_E1_CYC = int'((DOWN_HOLD_E1_MS * CLK_HZ + 999) / 1000);
    localparam int AUTO_HOLD_CYC = int'((AUTO_HOLD_DSEC * CLK_HZ + 9) / 10);
endpackage : alarm_flags_pkg

// ### design/alarm_status_qualifier.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_status_qualifier #(
    parameter int UP_HOLD = alarm_flags_pkg::UP_HOLD_CYC,
    parameter int DOWN_E1 = alarm_flags_pkg::DOWN_HOLD_E1_CYC,
    parameter int AUTO_HOLD = alarm_flags_pkg::AUTO_HOLD_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_sys_ais,
    input wire logic i_line_ais,
    input wire logic i_pattern_sync,
    input wire logic i_up_code,
    input wire logic i_down_code,
    input wire logic i_auto_loopback,
    input wire logic i_e1_mode,
    output logic [7:0] o_status
);
    typedef struct packed {
        alarm_flags_pkg::count_type up_cnt;
        alarm_flags_pkg::count_type down_cnt;
        logic [7:0] status;
    } state_type;

    state_type r_reg;
    state_type r_next;
    alarm_flags_pkg::count_type up_lim;
    alarm_flags_pkg::count_type down_lim;

    // saturating persistence counter; cleared as soon as the code drops
    function automatic alarm_flags_pkg::count_type hold_count(
        input logic code, input alarm_flags_pkg::count_type cnt,
        input alarm_flags_pkg::count_type lim);
        if (!code) begin
            return '0;
        end
        return (cnt < lim) ? cnt + 1'b1 : cnt;
    endfunction : hold_count

    always_comb begin
        up_lim = i_auto_loopback ? alarm_flags_pkg::count_type'(AUTO_HOLD)
                                 : alarm_flags_pkg::count_type'(UP_HOLD);
        if (i_auto_loopback) begin
            down_lim = alarm_flags_pkg::count_type'(AUTO_HOLD);
        end else if (i_e1_mode) begin
            down_lim = alarm_flags_pkg::count_type'(DOWN_E1);
        end else begin
            down_lim = alarm_flags_pkg::count_type'(UP_HOLD);
        end
        r_next = r_reg;
        r_next.up_cnt = hold_count(i_up_code, r_reg.up_cnt, up_lim);
        r_next.down_cnt = hold_count(i_down_code, r_reg.down_cnt, down_lim);
        r_next.status = alarm_flags_pkg::STATUS_RST;
        r_next.status[alarm_flags_pkg::ST_SYS_AIS] = i_sys_ais;
        r_next.status[alarm_flags_pkg::ST_LINE_AIS] = i_line_ais;
        r_next.status[alarm_flags_pkg::ST_PATTERN] = i_pattern_sync;
        // bit rises one cycle after the hold has fully elapsed
        r_next.status[alarm_flags_pkg::ST_UP] = i_up_code && (r_reg.up_cnt >= up_lim);
        r_next.status[alarm_flags_pkg::ST_DOWN] = i_down_code && (r_reg.down_cnt >= down_lim);
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r_reg <= '{up_cnt: '0, down_cnt: '0, status: alarm_flags_pkg::STATUS_RST};
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_status = r_reg.status;
endmodule : alarm_status_qualifier
`default_nettype wire

// ### design/line_alarm_status_event_flags.sv
`timescale 1ns/1ps
`default_nettype none
module line_alarm_status_event_flags #(
    parameter int UP_HOLD = alarm_flags_pkg::UP_HOLD_CYC,
    parameter int DOWN_E1 = alarm_flags_pkg::DOWN_HOLD_E1_CYC,
    parameter int AUTO_HOLD = alarm_flags_pkg::AUTO_HOLD_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [alarm_flags_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [alarm_flags_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [alarm_flags_pkg::NUM_STAT-1:0] i_sys_alarm_ind,
    input wire logic [alarm_flags_pkg::NUM_STAT-1:0] i_line_alarm_ind,
    input wire logic [alarm_flags_pkg::NUM_STAT-1:0] i_pattern_sync,
    input wire logic [alarm_flags_pkg::NUM_STAT-1:0] i_loop_up_code,
    input wire logic [alarm_flags_pkg::NUM_STAT-1:0] i_loop_down_code,
    input wire logic [alarm_flags_pkg::NUM_CH-1:0] i_tx_overcurrent_state,
    input wire logic [alarm_flags_pkg::NUM_CH-1:0] i_tx_clock_missing_state,
    input wire logic [alarm_flags_pkg::NUM_CH-1:0] i_tx_signal_loss_state,
    input wire logic [alarm_flags_pkg::NUM_CH-1:0] i_sys_signal_loss_state,
    input wire logic [alarm_flags_pkg::NUM_CH-1:0] i_line_signal_loss_state,
    input wire logic [alarm_flags_pkg::NUM_CH-1:0] i_amplitude_overflow,
    input wire logic [alarm_flags_pkg::NUM_CH-1:0] i_tx_jitter_fifo_slip,
    input wire logic [alarm_flags_pkg::NUM_CH-1:0] i_rx_jitter_fifo_slip,
    output logic o_irq
);
    localparam int NCH = alarm_flags_pkg::NUM_CH;
    localparam int NST = alarm_flags_pkg::NUM_STAT;
    localparam int IW = alarm_flags_pkg::IDX_W;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_STATUS,
        KIND_CH0_STATUS,
        KIND_FLAGS,
        KIND_MASK,
        KIND_EDGE,
        KIND_CTRL
    } kind_type;

    typedef struct packed {
        kind_type kind;
        logic [alarm_flags_pkg::CH_W-1:0] ch;
    } decode_type;

    typedef struct packed {
        logic aw_full;
        logic [IW-1:0] aw_idx;
        logic w_full;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NCH-1:0][7:0] flags;
        logic [NCH-1:0][7:0] mask;
        logic [NCH-1:0][7:0] edge_sel;
        logic [NCH-1:0][alarm_flags_pkg::LINE_W-1:0] line_prev;
        logic [7:0] ctrl;
        logic irq;
    } state_type;

    state_type r_reg;
    state_type r_next;
    logic [NST-1:0][7:0] stat;
    logic [NCH-1:0][7:0] clr;
    logic [NCH-1:0][7:0] set;
    logic [NCH-1:0][alarm_flags_pkg::LINE_W-1:0] line_now;
    decode_type wr_dec;
    decode_type rd_dec;
    logic wr_go;
    logic [IW-1:0] rd_idx;

    // the low six index bits select the register inside a channel block
    function automatic decode_type decode(input logic [IW-1:0] idx);
        decode_type d;
        d.ch = idx[alarm_flags_pkg::CH_LSB +: alarm_flags_pkg::CH_W];
        d.kind = KIND_NONE;
        if (idx == alarm_flags_pkg::CH0_STATUS_IDX) begin
            d.kind = KIND_CH0_STATUS;
        end else if (idx == alarm_flags_pkg::CONTROL_IDX) begin
            d.kind = KIND_CTRL;
        end else if (idx < NCH * alarm_flags_pkg::CH_STRIDE_IDX) begin
            case (idx[alarm_flags_pkg::CH_LSB-1:0])
                alarm_flags_pkg::CH1_STATUS_IDX[alarm_flags_pkg::CH_LSB-1:0]: begin
                    d.kind = KIND_STATUS;
                end
                alarm_flags_pkg::CH1_FLAGS_IDX[alarm_flags_pkg::CH_LSB-1:0]: begin
                    d.kind = KIND_FLAGS;
                end
                alarm_flags_pkg::CH1_MASK_IDX[alarm_flags_pkg::CH_LSB-1:0]: begin
                    d.kind = KIND_MASK;
                end
                alarm_flags_pkg::CH1_EDGE_IDX[alarm_flags_pkg::CH_LSB-1:0]: begin
                    d.kind = KIND_EDGE;
                end
                default: begin
                    d.kind = KIND_NONE;
                end
            endcase
        end
        return d;
    endfunction : decode

    // rising edge only, or either edge when the select bit is one
    function automatic logic edge_hit(input logic prev, input logic now, input logic both);
        return both ? (prev ^ now) : (~prev & now);
    endfunction : edge_hit

    // index 0 is the extra channel, index n is channel n
    for (genvar s = 0; s < NST; s++) begin : g_status
        alarm_status_qualifier #(
            .UP_HOLD(UP_HOLD),
            .DOWN_E1(DOWN_E1),
            .AUTO_HOLD(AUTO_HOLD)
        ) u_qual (
            .i_ref_clk(i_ref_clk),
            .i_rstn(i_rstn),
            .i_sys_ais(i_sys_alarm_ind[s]),
            .i_line_ais(i_line_alarm_ind[s]),
            .i_pattern_sync(i_pattern_sync[s]),
            .i_up_code(i_loop_up_code[s]),
            .i_down_code(i_loop_down_code[s]),
            .i_auto_loopback(r_reg.ctrl[alarm_flags_pkg::CTL_AUTO]),
            .i_e1_mode(r_reg.ctrl[alarm_flags_pkg::CTL_E1]),
            .o_status(stat[s])
        );
    end

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            line_now[c][alarm_flags_pkg::FL_TOC] = i_tx_overcurrent_state[c];
            line_now[c][alarm_flags_pkg::FL_TCK] = i_tx_clock_missing_state[c];
            line_now[c][alarm_flags_pkg::FL_TLOS] = i_tx_signal_loss_state[c];
            line_now[c][alarm_flags_pkg::FL_SLOS] = i_sys_signal_loss_state[c];
            line_now[c][alarm_flags_pkg::FL_LLOS] = i_line_signal_loss_state[c];
        end
    end

    always_comb begin
        r_next = r_reg;
        clr = '0;
        rd_idx = i_araddr[alarm_flags_pkg::IDX_LSB +: IW];
        wr_dec = decode(r_reg.aw_idx);
        rd_dec = decode(rd_idx);
        wr_go = r_reg.aw_full && r_reg.w_full && !r_reg.bvalid;

        // address and data are taken in either order
        if (i_awvalid && r_reg.awready) begin
            r_next.aw_full = 1'b1;
            r_next.aw_idx = i_awaddr[alarm_flags_pkg::IDX_LSB +: IW];
        end
        if (i_wvalid && r_reg.wready) begin
            r_next.w_full = 1'b1;
            r_next.w_data = i_wdata[7:0];
            r_next.w_lane0 = i_wstrb[0];
        end
        if (r_reg.bvalid && i_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (wr_go) begin
            r_next.aw_full = 1'b0;
            r_next.w_full = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = alarm_flags_pkg::RESP_OKAY;
            // status writes are accepted and have no effect
            case (wr_dec.kind)
                KIND_FLAGS: begin
                    if (r_reg.w_lane0) begin
                        clr[wr_dec.ch] = r_reg.w_data;
                    end
                end
                KIND_MASK: begin
                    if (r_reg.w_lane0) begin
                        r_next.mask[wr_dec.ch] = r_reg.w_data;
                    end
                end
                KIND_EDGE: begin
                    if (r_reg.w_lane0) begin
                        r_next.edge_sel[wr_dec.ch] = r_reg.w_data & alarm_flags_pkg::EDGE_WMASK;
                    end
                end
                KIND_CTRL: begin
                    if (r_reg.w_lane0) begin
                        r_next.ctrl = r_reg.w_data & alarm_flags_pkg::CTL_WMASK;
                    end
                end
                KIND_STATUS, KIND_CH0_STATUS: begin
                    r_next.bresp = alarm_flags_pkg::RESP_OKAY;
                end
                default: begin
                    r_next.bresp = alarm_flags_pkg::RESP_SLVERR;
                end
            endcase
        end
        // one write in flight: readies stay low until the response is taken
        r_next.awready = !r_next.aw_full && !r_next.bvalid;
        r_next.wready = !r_next.w_full && !r_next.bvalid;

        if (r_reg.rvalid && i_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (i_arvalid && r_reg.arready) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = alarm_flags_pkg::RESP_OKAY;
            r_next.rdata = '0;
            case (rd_dec.kind)
                KIND_STATUS: begin
                    r_next.rdata[7:0] = stat[{1'b0, rd_dec.ch} + 5'd1];
                end
                KIND_CH0_STATUS: begin
                    r_next.rdata[7:0] = stat[0];
                end
                KIND_FLAGS: begin
                    r_next.rdata[7:0] = r_reg.flags[rd_dec.ch];
                end
                KIND_MASK: begin
                    r_next.rdata[7:0] = r_reg.mask[rd_dec.ch];
                end
                KIND_EDGE: begin
                    r_next.rdata[7:0] = r_reg.edge_sel[rd_dec.ch];
                end
                KIND_CTRL: begin
                    r_next.rdata[7:0] = r_reg.ctrl;
                end
                default: begin
                    r_next.rresp = alarm_flags_pkg::RESP_SLVERR;
                end
            endcase
        end
        r_next.arready = !r_next.rvalid;

        for (int c = 0; c < NCH; c++) begin
            set[c][alarm_flags_pkg::FL_AMP] = i_amplitude_overflow[c];
            set[c][alarm_flags_pkg::FL_TJA] = i_tx_jitter_fifo_slip[c];
            set[c][alarm_flags_pkg::FL_RJA] = i_rx_jitter_fifo_slip[c];
            set[c][alarm_flags_pkg::FL_TOC] = edge_hit(r_reg.line_prev[c][alarm_flags_pkg::FL_TOC],
                line_now[c][alarm_flags_pkg::FL_TOC], r_reg.edge_sel[c][alarm_flags_pkg::ES_TOC]);
            set[c][alarm_flags_pkg::FL_TCK] = edge_hit(r_reg.line_prev[c][alarm_flags_pkg::FL_TCK],
                line_now[c][alarm_flags_pkg::FL_TCK], r_reg.edge_sel[c][alarm_flags_pkg::ES_TCK]);
            set[c][alarm_flags_pkg::FL_TLOS] = edge_hit(r_reg.line_prev[c][alarm_flags_pkg::FL_TLOS],
                line_now[c][alarm_flags_pkg::FL_TLOS], r_reg.edge_sel[c][alarm_flags_pkg::ES_TLOS]);
            set[c][alarm_flags_pkg::FL_SLOS] = edge_hit(r_reg.line_prev[c][alarm_flags_pkg::FL_SLOS],
                line_now[c][alarm_flags_pkg::FL_SLOS], r_reg.edge_sel[c][alarm_flags_pkg::ES_LOS]);
            set[c][alarm_flags_pkg::FL_LLOS] = edge_hit(r_reg.line_prev[c][alarm_flags_pkg::FL_LLOS],
                line_now[c][alarm_flags_pkg::FL_LLOS], r_reg.edge_sel[c][alarm_flags_pkg::ES_LOS]);
            // set after clear, so an event in the clearing cycle survives
            r_next.flags[c] = (r_reg.flags[c] & ~clr[c]) | set[c];
            r_next.line_prev[c] = line_now[c];
        end
        // masked flags still latch; only the pin is gated
        r_next.irq = |(r_next.flags & ~r_next.mask);
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r_reg <= '0;
            r_reg.flags <= {NCH{alarm_flags_pkg::FLAGS_RST}};
            r_reg.mask <= {NCH{alarm_flags_pkg::MASK_RST}};
            r_reg.edge_sel <= {NCH{alarm_flags_pkg::EDGE_RST}};
            r_reg.ctrl <= alarm_flags_pkg::CTL_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_awready = r_reg.awready;
    assign o_wready = r_reg.wready;
    assign o_bvalid = r_reg.bvalid;
    assign o_bresp = r_reg.bresp;
    assign o_arready = r_reg.arready;
    assign o_rvalid = r_reg.rvalid;
    assign o_rdata = r_reg.rdata;
    assign o_rresp = r_reg.rresp;
    assign o_irq = r_reg.irq;
endmodule : line_alarm_status_event_flags
`default_nettype wire

// ### tb/alarm_flags_props.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_flags_props (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [alarm_flags_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic o_irq
);
    logic [5:0] ra_reg;
    logic wrote_reg;
    // aw taken, not bvalid: a mask write may raise irq at the edge bvalid rises
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ra_reg <= 6'h00;
            wrote_reg <= 1'b0;
        end else begin
            if (i_arvalid && o_arready) ra_reg <= i_araddr[7:2];
            if (i_awvalid && o_awready) wrote_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer missing");
    a_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read answer dropped");
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> !o_bvalid ##1 o_bvalid)
        else $error("write answer timing");
    a_write_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write answer dropped");
    a_read_block: assert property (o_rvalid |-> !o_arready)
        else $error("read accepted while answering");
    a_write_block: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write accepted while answering");
    a_upper_zero: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_status_reserved: assert property (o_rvalid && ra_reg == 6'h1F |-> o_rdata[4:2] == 3'h0)
        else $error("reserved status bits set");
    a_irq_default: assert property (!wrote_reg |-> !o_irq)
        else $error("irq before any mask write");
endmodule : alarm_flags_props
`default_nettype wire

// ### tb/axi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module axi_host_model (
    input wire logic i_ref_clk,
    output var logic [12:0] o_awaddr,
    output var logic o_awvalid,
    output var logic [31:0] o_wdata,
    output var logic [3:0] o_wstrb,
    output var logic o_wvalid,
    output var logic o_bready,
    output var logic [12:0] o_araddr,
    output var logic o_arvalid,
    output var logic o_rready,
    input wire logic i_awready,
    input wire logic i_wready,
    input wire logic [1:0] i_bresp,
    input wire logic i_bvalid,
    input wire logic i_arready,
    input wire logic [31:0] i_rdata,
    input wire logic [1:0] i_rresp,
    input wire logic i_rvalid
);
    initial begin
        {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
        {o_araddr, o_arvalid, o_rready} = '0;
    end
    // no wait is bounded here; the bench watchdog cuts a hang
    task automatic wr(input logic [12:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge i_ref_clk);
        o_awaddr <= a;
        o_awvalid <= 1'b1;
        o_wdata <= {24'h0, d};
        o_wstrb <= 4'hF;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        while (aw || w) begin
            @(posedge i_ref_clk);
            if (aw && i_awready) begin
                aw = 1'b0;
                o_awvalid <= 1'b0;
            end
            if (w && i_wready) begin
                w = 1'b0;
                o_wvalid <= 1'b0;
            end
        end
        do @(posedge i_ref_clk); while (i_bvalid !== 1'b1);
        r = i_bresp;
        o_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_ref_clk);
        o_araddr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        do @(posedge i_ref_clk); while (i_arready !== 1'b1);
        o_arvalid <= 1'b0;
        do @(posedge i_ref_clk); while (i_rvalid !== 1'b1);
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
    endtask : rd
endmodule : axi_host_model
`default_nettype wire

// ### tb/line_alarm_status_event_flags_bench.sv
`timescale 1ns/1ps
`default_nettype none
module line_alarm_status_event_flags_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [12:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
    logic [16:0] sai = '0, lai = '0, pat = '0, upc = '0, dnc = '0;
    logic [15:0] ls [5] = '{default: '0};
    logic [15:0] ev [3] = '{default: '0};
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] d;
    logic [1:0] r;
    always #10 clk = ~clk;
    axi_host_model host (.i_ref_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .o_wdata(wdata),
        .o_wstrb(wstrb), .o_wvalid(wvalid), .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
        .o_rready(rready), .i_awready(awready), .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid),
        .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid));
    // short hold limits keep the run small
    line_alarm_status_event_flags #(.UP_HOLD(20), .DOWN_E1(15), .AUTO_HOLD(60)) uut (
        .i_ref_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_sys_alarm_ind(sai),
        .i_line_alarm_ind(lai), .i_pattern_sync(pat), .i_loop_up_code(upc), .i_loop_down_code(dnc),
        .i_tx_overcurrent_state(ls[4]), .i_tx_clock_missing_state(ls[3]), .i_tx_signal_loss_state(ls[2]),
        .i_sys_signal_loss_state(ls[1]), .i_line_signal_loss_state(ls[0]), .i_amplitude_overflow(ev[2]),
        .i_tx_jitter_fifo_slip(ev[1]), .i_rx_jitter_fifo_slip(ev[0]), .o_irq(irq));
    task automatic close_out;
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    function automatic logic [12:0] ad(input int k, input int n);
        logic [10:0] b;
        case (k)
            0: b = alarm_flags_pkg::CH1_STATUS_IDX;
            1: b = alarm_flags_pkg::CH1_FLAGS_IDX;
            2: b = alarm_flags_pkg::CH1_MASK_IDX;
            default: b = alarm_flags_pkg::CH1_EDGE_IDX;
        endcase
        return {b + alarm_flags_pkg::CH_STRIDE_IDX * 11'(n - 1), 2'b00};
    endfunction : ad
    task automatic rc(input string n, input logic [12:0] a, input logic [7:0] e);
        host.rd(a, d, r);
        chk(n, {24'h0, e}, d);
        chk({n, " resp"}, 32'(alarm_flags_pkg::RESP_OKAY), 32'(r));
    endtask : rc
    task automatic t_reset;
        rc("status ch1", ad(0, 1), 8'h00);
        rc("flags ch1", ad(1, 1), 8'h00);
        rc("mask ch4", ad(2, 4), 8'hFF);
        rc("edge ch4", ad(3, 4), 8'h00);
        host.rd(13'h1FFC, d, r);
        chk("unmapped resp", 32'(alarm_flags_pkg::RESP_SLVERR), 32'(r));
        host.wr(ad(0, 1), 8'hFF, r);
        chk("status write resp", 32'(alarm_flags_pkg::RESP_OKAY), 32'(r));
        rc("status after write", ad(0, 1), 8'h00);
    endtask : t_reset
    task automatic t_status;
        @(posedge clk);
        sai[3] <= 1'b1;
        pat[3] <= 1'b1;
        pat[0] <= 1'b1;
        lai[16] <= 1'b1;
        repeat (2) @(posedge clk);
        rc("status ch3", ad(0, 3), 8'hA0);
        rc("status ch16", ad(0, 16), 8'h40);
        rc("status ch0", {alarm_flags_pkg::CH0_STATUS_IDX, 2'b00}, 8'h20);
        sai <= '0;
        pat <= '0;
        lai <= '0;
    endtask : t_status
    // early read lands near lim-3 cycles, late read near lim+3
    task automatic t_hold(input int ch, input logic down, input logic [7:0] ctl, input int lim);
        host.wr({alarm_flags_pkg::CONTROL_IDX, 2'b00}, ctl, r);
        @(posedge clk);
        dnc[ch] <= down;
        upc[ch] <= !down;
        repeat (lim - 5) @(posedge clk);
        rc("hold early", ad(0, ch), 8'h00);
        repeat (3) @(posedge clk);
        rc("hold late", ad(0, ch), down ? 8'h01 : 8'h02);
        dnc <= '0;
        upc <= '0;
        repeat (3) @(posedge clk);
        rc("hold dropped", ad(0, ch), 8'h00);
    endtask : t_hold
    task automatic t_edges;
        logic [7:0] es [3];
        es = '{8'h00, 8'h02, 8'h1C};
        for (int e = 0; e < 3; e++) begin
            host.wr(ad(3, 5), es[e], r);
            for (int b = 0; b < 5; b++) begin
                host.wr(ad(1, 5), 8'hFF, r);
                ls[b][4] <= 1'b1;
                repeat (2) @(posedge clk);
                rc("rise", ad(1, 5), 8'(1 << b));
                host.wr(ad(1, 5), 8'(1 << b), r);
                rc("cleared", ad(1, 5), 8'h00);
                ls[b][4] <= 1'b0;
                repeat (2) @(posedge clk);
                rc("fall", ad(1, 5), es[e][b < 2 ? 1 : b] ? 8'(1 << b) : 8'h00);
            end
        end
    endtask : t_edges
    task automatic t_events;
        logic [7:0] e;
        e = 8'h00;
        host.wr(ad(2, 16), 8'h7F, r);
        for (int b = 5; b < 8; b++) begin
            @(posedge clk);
            ev[b - 5][15] <= 1'b1;
            @(posedge clk);
            ev[b - 5][15] <= 1'b0;
            e[b] = 1'b1;
            repeat (2) @(posedge clk);
            rc("event flags", ad(1, 16), e);
            chk("irq", 32'(b == 7), 32'(irq));
        end
        host.wr(ad(1, 16), 8'h00, r);
        rc("zero write", ad(1, 16), 8'hE0);
        host.wr(ad(1, 16), 8'hE0, r);
        rc("w1c", ad(1, 16), 8'h00);
        chk("irq released", 32'h0, 32'(irq));
    endtask : t_events
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_status();
        t_hold(1, 1'b0, 8'h00, 20);
        t_hold(2, 1'b0, 8'h01, 60);
        t_hold(7, 1'b1, 8'h02, 15);
        t_hold(9, 1'b1, 8'h03, 60);
        t_hold(4, 1'b1, 8'h00, 20);
        t_edges();
        t_events();
        close_out();
    end
endmodule : line_alarm_status_event_flags_bench
bind line_alarm_status_event_flags alarm_flags_props chk (.i_ref_clk, .i_rstn, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .o_irq);
`default_nettype wire
